/* pec_pkg.sv */
/*
  Package for the power event and clock stop block: register offsets, field positions,
  reset values, timing constants and the packed structs that carry pin groups.
  Assumes a 20 MHz bus clock and a 32-bit APB register bus.
*/
package pec_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned DEBOUNCE_MS = 16;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned DB_W = 20;
  localparam int unsigned EXT_REARM_CYC = 4;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_PINS = 8'h10;

  // Event bit positions shared by status, clear and enable.
  localparam int unsigned EV_EXT = 0;
  localparam int unsigned EV_LID = 1;
  localparam int unsigned EV_PWR = 2;
  localparam int unsigned EV_RING = 3;
  localparam int unsigned EV_REQ = 4;
  localparam int unsigned EV_SERIAL = 5;
  localparam int unsigned EV_N = 6;

  // Control register fields.
  localparam int unsigned CT_CPU_STOP = 0;
  localparam int unsigned CT_BUS_STOP = 1;
  localparam int unsigned CT_BATTERY_LOW_N_BLOCK = 2;
  localparam int unsigned CT_N = 3;
  localparam logic [CT_N-1:0] CTRL_RST = 3'h0;
  localparam logic [EV_N-1:0] EN_RST = 6'h00;

  // Pin readback fields.
  localparam int unsigned PN_BATTERY_LOW_N = 0;
  localparam int unsigned PN_LID = 1;
  localparam int unsigned PN_RING = 2;
  localparam int unsigned PN_PWR = 3;
  localparam int unsigned PN_REQ = 4;
  localparam int unsigned PN_WAKE = 8;

  localparam int unsigned NREQ = 4;

  typedef struct packed {
    logic battery_low_n;
    logic lid;
    logic power_button_n;
    logic ring_indicate_n;
    logic [NREQ-1:0] master_request_mon_n;
  } pec_events_t;

  typedef struct packed {
    logic usb_port_a_pos;
    logic usb_port_a_neg;
    logic usb_port_b_pos;
    logic usb_port_b_neg;
  } pec_usb_t;

endpackage : pec_pkg

/* pec_top.sv */
/*
  Power event and clock stop block: event capture, debounce, management interrupt,
  clock stop requests and USB pin idle control, with an APB register slave.
  Assumes all inputs except the external management interrupt pin are synchronous
  to clk_i, and that the bus clock keeps running while other bus clocks stop.
*/
`timescale 1ns/1ps
module pec_top
  import pec_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic resume_well_reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Event inputs
  input wire pec_events_t events_i,
  input wire logic suspended_i,
  input wire logic serial_mgmt_req_i,
  // External management interrupt open-drain pin
  input wire logic ext_mgmt_irq_n_i,
  output logic ext_mgmt_irq_n_o,
  output logic ext_mgmt_irq_n_oe_o,
  // Outputs
  output logic mgmt_irq_n_o,
  output logic irq_o,
  output logic wake_o,
  output logic cpu_clock_stop_n_o,
  output logic bus_clock_stop_n_o,
  output pec_usb_t usb_o,
  output pec_usb_t usb_oe_o
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [EV_N-1:0] status;
  logic [EV_N-1:0] enable;
  logic [CT_N-1:0] ctrl;
  logic [EV_N-1:0] ev_pulse;
  logic [EV_N-1:0] clr_mask;
  logic wr_en;
  logic rd_en;
  logic lid_db;
  logic pwr_db;
  logic wake_req;

  // Read data is loaded in the setup cycle, so it already stands at the access edge.
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign clr_mask = (wr_en && paddr_i == ADDR_CLEAR) ? pwdata_i[EV_N-1:0] : '0;

  // Enable and control live in the suspend well so they survive system reset.
  always_ff @(posedge clk_i or negedge resume_well_reset_n_i) begin
    if (!resume_well_reset_n_i) begin
      enable <= EN_RST;
      ctrl <= CTRL_RST;
    end else if (wr_en) begin
      if (paddr_i == ADDR_ENABLE) begin
        enable <= pwdata_i[EV_N-1:0];
      end
      if (paddr_i == ADDR_CTRL) begin
        ctrl <= pwdata_i[CT_N-1:0];
      end
    end
  end

  // Status is sticky; an event in the same cycle as its clear wins.
  always_ff @(posedge clk_i or negedge resume_well_reset_n_i) begin
    if (!resume_well_reset_n_i) begin
      status <= '0;
    end else begin
      status <= (status & ~clr_mask) | ev_pulse;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o <= '0;
    end else if (rd_en) begin
      prdata_o <= '0;
      case (paddr_i)
        ADDR_STATUS: prdata_o[EV_N-1:0] <= status;
        ADDR_ENABLE: prdata_o[EV_N-1:0] <= enable;
        ADDR_CTRL: prdata_o[CT_N-1:0] <= ctrl;
        ADDR_PINS: begin
          prdata_o[PN_BATTERY_LOW_N] <= events_i.battery_low_n;
          prdata_o[PN_LID] <= events_i.lid;
          prdata_o[PN_RING] <= events_i.ring_indicate_n;
          prdata_o[PN_PWR] <= pwr_db;
          prdata_o[PN_REQ +: NREQ] <= events_i.master_request_mon_n;
          prdata_o[PN_WAKE] <= wake_req;
        end
        default: prdata_o <= '0;
      endcase
    end
  end

  // ****************************************************************
  // External management interrupt edge detect
  // ****************************************************************
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic [2:0] rearm_cnt;
  logic armed;

  // The pin is asynchronous; two flops before any edge logic looks at it.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
    end else begin
      ext_s1 <= ext_mgmt_irq_n_i;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // The detector rearms only after the line has been high for a few clocks.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rearm_cnt <= '0;
      armed <= 1'b0;
    end else if (!ext_s2) begin
      rearm_cnt <= '0;
      armed <= 1'b0;
    end else if (rearm_cnt < 3'(EXT_REARM_CYC - 1)) begin
      rearm_cnt <= rearm_cnt + 3'd1;
    end else begin
      armed <= 1'b1;
    end
  end

  assign ev_pulse[EV_EXT] = armed & ext_s3 & ~ext_s2 & enable[EV_EXT];

  // The block drives the shared pin low only for its own serial interrupt request.
  assign ext_mgmt_irq_n_o = 1'b0;
  assign ext_mgmt_irq_n_oe_o = serial_mgmt_req_i;
  assign ev_pulse[EV_SERIAL] = 1'b0;

  // ****************************************************************
  // Debounce for lid and power button
  // ****************************************************************
  logic [1:0] db_in;
  logic [1:0] db_out;
  logic [1:0] db_edge;
  assign db_in = {events_i.power_button_n, events_i.lid};

  generate
    for (genvar g = 0; g < 2; g++) begin : g_db
      logic [DB_W-1:0] cnt;
      logic stable;
      // A new level is accepted only after it has held for the whole interval.
      always_ff @(posedge clk_i or negedge resume_well_reset_n_i) begin
        if (!resume_well_reset_n_i) begin
          cnt <= '0;
          stable <= 1'b1;
        end else if (db_in[g] == stable) begin
          cnt <= '0;
        end else if (cnt >= DB_W'(DEBOUNCE_CYCLES - 1)) begin
          cnt <= '0;
          stable <= db_in[g];
        end else begin
          cnt <= cnt + DB_W'(1);
        end
      end
      assign db_out[g] = stable;
      assign db_edge[g] = (db_in[g] != stable) && (cnt >= DB_W'(DEBOUNCE_CYCLES - 1));
    end
  endgenerate

  assign lid_db = db_out[0];
  assign pwr_db = db_out[1];
  assign ev_pulse[EV_LID] = db_edge[0] & enable[EV_LID];
  assign ev_pulse[EV_PWR] = db_edge[1] & ~db_in[1] & enable[EV_PWR];

  // ****************************************************************
  // Ring indicate and bus master activity
  // ****************************************************************
  logic ring_q;
  logic [NREQ-1:0] req_q;

  always_ff @(posedge clk_i or negedge resume_well_reset_n_i) begin
    if (!resume_well_reset_n_i) begin
      ring_q <= 1'b1;
      req_q <= '1;
    end else begin
      ring_q <= events_i.ring_indicate_n;
      req_q <= events_i.master_request_mon_n;
    end
  end

  assign ev_pulse[EV_RING] = ring_q & ~events_i.ring_indicate_n & enable[EV_RING];
  assign ev_pulse[EV_REQ] = (|(req_q & ~events_i.master_request_mon_n))
                            & enable[EV_REQ];

  // ****************************************************************
  // Interrupt, wake and clock stop outputs
  // ****************************************************************
  logic irq_q;
  logic blocked;

  assign blocked = ctrl[CT_BATTERY_LOW_N_BLOCK] & ~events_i.battery_low_n;
  assign wake_req = suspended_i & (|(status & enable)) & ~blocked;
  assign irq_o = |(status & enable);
  assign mgmt_irq_n_o = ~irq_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_q <= 1'b0;
      wake_o <= 1'b0;
      cpu_clock_stop_n_o <= 1'b1;
      bus_clock_stop_n_o <= 1'b1;
    end else begin
      irq_q <= |(status & enable);
      wake_o <= wake_req;
      cpu_clock_stop_n_o <= ~ctrl[CT_CPU_STOP];
      bus_clock_stop_n_o <= ~ctrl[CT_BUS_STOP];
    end
  end

  // The USB transceiver logic is outside this block, so its pins stay released.
  assign usb_o = '0;
  assign usb_oe_o = '0;

  logic unused_ok;
  assign unused_ok = ^{pwdata_i[31:EV_N], lid_db};

endmodule : pec_top

/* pec_chk.sv */
/* Port checker for the power event block.
   Assumes binding to pec_top and clean resets at start. */
`timescale 1ns/1ps
module pec_chk
  import pec_pkg::*;
#(parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC) (
  // Clock, resets and bus
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic resume_well_reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  // Pins
  input wire pec_events_t events_i,
  input wire logic serial_mgmt_req_i,
  input wire logic ext_mgmt_irq_n_i,
  input wire logic ext_mgmt_irq_n_o,
  input wire logic ext_mgmt_irq_n_oe_o,
  input wire logic mgmt_irq_n_o,
  input wire logic irq_o,
  input wire logic wake_o,
  input wire logic cpu_clock_stop_n_o,
  input wire logic bus_clock_stop_n_o,
  input wire pec_usb_t usb_oe_o
);
  // ****************************************************************
  // Shadow of enable and block bits
  // ****************************************************************
  logic [EV_N-1:0] en_q;
  logic block_q;
  logic wr_w;
  assign wr_w = psel_i && penable_i && pready_o && pwrite_i;
  always_ff @(posedge clk_i or negedge resume_well_reset_n_i) begin
    if (!resume_well_reset_n_i) begin
      en_q <= EN_RST;
      block_q <= 1'b0;
    end else if (wr_w && paddr_i == ADDR_ENABLE) begin
      en_q <= pwdata_i[EV_N-1:0];
    end else if (wr_w && paddr_i == ADDR_CTRL) begin
      block_q <= pwdata_i[CT_BATTERY_LOW_N_BLOCK];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i || !resume_well_reset_n_i);
  usb_idle_a: assert property (usb_oe_o == 4'h0)
    else $error("usb pins driven");
  cpu_stop_a: assert property (wr_w && paddr_i == ADDR_CTRL |->
    ##2 cpu_clock_stop_n_o == !$past(pwdata_i[CT_CPU_STOP], 2)) else $error("cpu stop wrong");
  bus_stop_a: assert property (wr_w && paddr_i == ADDR_CTRL |->
    ##2 bus_clock_stop_n_o == !$past(pwdata_i[CT_BUS_STOP], 2)) else $error("bus stop wrong");
  ext_edge_a: assert property ($fell(ext_mgmt_irq_n_i) && en_q[EV_EXT] |->
    ##[1:8] !mgmt_irq_n_o) else $error("ext edge missed");
  irq_follow_a: assert property ($past(nrst_i) |-> mgmt_irq_n_o == !$past(irq_o))
    else $error("mgmt irq lags wrong");
  serial_drive_a: assert property (ext_mgmt_irq_n_oe_o == serial_mgmt_req_i
    && !ext_mgmt_irq_n_o) else $error("serial drive wrong");
  disabled_quiet_a: assert property (en_q == EN_RST ##1 en_q == EN_RST |->
    !irq_o && mgmt_irq_n_o && !wake_o) else $error("irq or wake while disabled");
  wake_block_a: assert property (block_q && !events_i.battery_low_n ##1
    block_q && !events_i.battery_low_n |-> !wake_o) else $error("wake not blocked");
endmodule : pec_chk
bind pec_top pec_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_pec_chk (.clk_i, .nrst_i,
  .resume_well_reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
  .events_i, .serial_mgmt_req_i, .ext_mgmt_irq_n_i, .ext_mgmt_irq_n_o, .ext_mgmt_irq_n_oe_o,
  .mgmt_irq_n_o, .irq_o, .wake_o, .cpu_clock_stop_n_o, .bus_clock_stop_n_o, .usb_oe_o);

/* pec_partner.sv */
/* Far side model: free clock and an external interrupt source.
   Assumes the pin has a pull-up and tasks start anywhere. */
`timescale 1ns/1ps
module pec_partner (
  // Clock and open-drain pin
  output logic clk_o,
  input wire logic dut_oe_i,
  output logic pin_o
);
  // ****************************************************************
  // Clock and pin
  // ****************************************************************
  logic src_low;
  initial begin
    clk_o = 1'b0;
    src_low = 1'b0;
    forever #25 clk_o = ~clk_o;
  end
  // The pull-up wins only while neither party pulls low.
  assign pin_o = !(dut_oe_i || src_low);
  task automatic pulse();
    @(posedge clk_o);
    src_low <= 1'b1;
    @(posedge clk_o);
    src_low <= 1'b0;
    repeat (4) @(posedge clk_o);
  endtask : pulse
endmodule : pec_partner

/* tb.sv */
/* Self-checking bench for pec_top over APB.
   Assumes pec_pkg constants and a short debounce count. */
`timescale 1ns/1ps
module tb;
  import pec_pkg::*;
  // ****************************************************************
  // Signals, tasks and tests
  // ****************************************************************
  localparam int unsigned DB = 8;
  logic clk_i, nrst_i, resume_well_reset_n_i, psel_i, penable_i, pwrite_i;
  logic serial_mgmt_req_i, suspended_i, ext_mgmt_irq_n_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic pready_o, pslverr_o, ext_mgmt_irq_n_o, ext_mgmt_irq_n_oe_o, mgmt_irq_n_o;
  logic irq_o, wake_o, cpu_clock_stop_n_o, bus_clock_stop_n_o;
  pec_events_t events_i;
  pec_usb_t usb_o, usb_oe_o;
  int n_errors = 0;
  int n_checks = 0;
  pec_top #(.DEBOUNCE_CYCLES(DB)) u_pec_top (.clk_i, .nrst_i, .resume_well_reset_n_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .events_i, .suspended_i, .serial_mgmt_req_i, .ext_mgmt_irq_n_i, .ext_mgmt_irq_n_o,
    .ext_mgmt_irq_n_oe_o, .mgmt_irq_n_o, .irq_o, .wake_o, .cpu_clock_stop_n_o,
    .bus_clock_stop_n_o, .usb_o, .usb_oe_o);
  pec_partner u_pec_partner (.clk_o(clk_i), .dut_oe_i(ext_mgmt_irq_n_oe_o),
    .pin_o(ext_mgmt_irq_n_i));
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Read data is taken at the edge where pready is seen high, then the request drops.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rdat = prdata_o;
    {psel_i, penable_i} <= 2'b00;
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask : rd_chk
  task automatic ev_case(input int b, input logic [7:0] f, input int h, input bit back,
      input logic [31:0] e);
    apb(1'b1, ADDR_CLEAR, 32'h0000_003F);
    apb(1'b1, ADDR_ENABLE, 32'(1) << b);
    @(posedge clk_i);
    events_i <= events_i ^ f;
    repeat (h) @(posedge clk_i);
    if (back) events_i <= events_i ^ f;
    repeat (DB + 10) @(posedge clk_i);
    rd_chk(ADDR_STATUS, e);
    chk(32'(irq_o), 32'(e != 0));
  endtask : ev_case
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end
  initial begin
    {nrst_i, resume_well_reset_n_i, psel_i, penable_i, pwrite_i} = 5'h00;
    {serial_mgmt_req_i, suspended_i, paddr_i, pwdata_i} = 42'h0;
    events_i = 8'hBF;
    repeat (12) @(posedge clk_i);
    {nrst_i, resume_well_reset_n_i} <= 2'b11;
    @(negedge clk_i);
    chk(32'({cpu_clock_stop_n_o, bus_clock_stop_n_o, mgmt_irq_n_o, pslverr_o, usb_oe_o,
      usb_o}), 32'h0000_0E00);
    for (int i = 0; i < 4; i++) rd_chk(8'(4 * i), 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CTRL, 32'(i));
      repeat (2) @(posedge clk_i);
      chk(32'({bus_clock_stop_n_o, cpu_clock_stop_n_o}), 32'(~i & 3));
    end
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    $display("test clock stop done");
    apb(1'b1, ADDR_ENABLE, 32'h0000_0001);
    u_pec_partner.pulse();
    repeat (4) @(posedge clk_i);
    chk(32'({irq_o, mgmt_irq_n_o}), 32'h2);
    rd_chk(ADDR_STATUS, 32'h0000_0001);
    apb(1'b1, ADDR_CLEAR, 32'h0000_0001);
    rd_chk(ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, ADDR_ENABLE, 32'h0000_0000);
    u_pec_partner.pulse();
    repeat (4) @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    serial_mgmt_req_i <= 1'b1;
    @(negedge clk_i);
    chk(32'({ext_mgmt_irq_n_oe_o, ext_mgmt_irq_n_i}), 32'h2);
    @(posedge clk_i);
    serial_mgmt_req_i <= 1'b0;
    $display("test ext irq done");
    ev_case(EV_LID, 8'h40, DB - 3, 1, 0);
    ev_case(EV_LID, 8'h40, 1, 0, 2);
    ev_case(EV_LID, 8'h40, 1, 0, 2);
    ev_case(EV_PWR, 8'h20, 1, 0, 4);
    ev_case(EV_PWR, 8'h20, 1, 0, 0);
    ev_case(EV_RING, 8'h10, 1, 0, 8);
    ev_case(EV_RING, 8'h10, 1, 0, 0);
    for (int k = 0; k < 4; k++) begin
      ev_case(EV_REQ, 8'(1 << k), 1, 0, 16);
      ev_case(EV_REQ, 8'(1 << k), 1, 0, 0);
    end
    rd_chk(ADDR_PINS, 32'h0000_00FD);
    $display("test events done");
    suspended_i <= 1'b1;
    ev_case(EV_RING, 8'h10, 1, 0, 8);
    chk(32'(wake_o), 32'h1);
    events_i <= 8'hBF;
    apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    events_i <= 8'h3F;
    ev_case(EV_RING, 8'h10, 1, 0, 8);
    chk(32'(wake_o), 32'h0);
    {suspended_i, events_i} <= 9'h0BF;
    $display("test wake done");
    apb(1'b1, ADDR_CLEAR, 32'h0000_003F);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    apb(1'b1, ADDR_ENABLE, 32'h0000_003F);
    @(posedge clk_i);
    resume_well_reset_n_i <= 1'b0;
    @(posedge clk_i);
    resume_well_reset_n_i <= 1'b1;
    rd_chk(ADDR_ENABLE, 32'h0000_0000);
    rd_chk(ADDR_CTRL, 32'h0000_0000);
    chk(32'({cpu_clock_stop_n_o, bus_clock_stop_n_o}), 32'h3);
    $display("test resume reset done");
    print_verdict();
  end
endmodule : tb
